// >>> src/dcs_regs.vh
// Register offsets, fields, reset values and timing counts of the capture sequencer
`ifndef DCS_REGS_VH
`define DCS_REGS_VH
`define DCS_ADDR_W 4
`define DCS_REG_CTRL 4'h0
`define DCS_REG_CMD 4'h1
`define DCS_REG_RECLEN 4'h2
`define DCS_REG_PRETRIG 4'h3
`define DCS_REG_RECCNT 4'h4
`define DCS_REG_STATUS 4'h5
`define DCS_REG_DONE 4'h6
`define DCS_REG_ID 4'h7
`define DCS_CTRL_DUAL 0
`define DCS_CTRL_CLK_LO 1
`define DCS_CTRL_CLK_HI 2
`define DCS_CTRL_TSRC_LO 3
`define DCS_CTRL_TSRC_HI 4
`define DCS_CTRL_AUX_LO 5
`define DCS_CTRL_AUX_HI 7
`define DCS_CTRL_IDLED 8
`define DCS_CTRL_DIGOUT 9
`define DCS_CTRL_DECIM_LO 16
`define DCS_CTRL_DECIM_HI 23
`define DCS_CMD_ARM 0
`define DCS_CMD_ABORT 1
`define DCS_CMD_PFCLR 2
`define DCS_CLK_INT 2'h0
`define DCS_CLK_FAST 2'h1
`define DCS_CLK_REF 2'h2
`define DCS_TSRC_A 2'h0
`define DCS_TSRC_B 2'h1
`define DCS_TSRC_EXT 2'h2
`define DCS_AUX_TRIGOUT 3'h0
`define DCS_AUX_PACER 3'h1
`define DCS_AUX_DIGOUT 3'h2
`define DCS_AUX_TRIGEN 3'h3
`define DCS_AUX_DIGIN 3'h4
`define DCS_RECLEN_MIN 32'h00000100
`define DCS_ALIGN_MASK 32'h0000000f
`define DCS_PRE_MAX_SINGLE 32'h00000ff0
`define DCS_PRE_MAX_DUAL 32'h000007f8
`define DCS_RECLEN_RST 32'h00000100
`define DCS_RECCNT_RST 32'h00000001
`define DCS_CLK_HZ 10000000
`define DCS_BASE_HZ 50000000
`define DCS_REF_HZ 10000000
`define DCS_FAST_MIN_HZ 1000000
`define DCS_FAST_MAX_HZ 50000000
`define DCS_HB_MS 100
`define DCS_HB_CYC ((`DCS_CLK_HZ / 1000) * `DCS_HB_MS)
`endif

// >>> src/dcs_sequencer.v
// Capture sequencer: checks configuration, arms, gates trigger, drives status indicators
// What this block does
// - Record length must be at least 256 and a multiple of 16.
// - Trigger detection waits until pretrigger samples are stored after arming.
// - Pretrigger depth latched at arm, used for all records of the session.
// - Single channel: pretrigger 0 to 4080 in steps of 16.
// - Dual channel: pretrigger 0 to 2032 in steps of 16.
// - Record count at least 1; counter never wraps into a stop.
// - Trigger indicator on during post-trigger capture, once per record.
// - Armed indicator on while armed, off for one cycle at each re-arm.
// - Internal clock indicator on only with internal clock selected.
// - Reference mode locks to 10 MHz, gives 50 MHz, decimates lower rates.
// - Heartbeat toggles while base clock runs at 50 MHz.
// - Clock-loss indicator on while the base oscillator is not running.
// - Power-fault indicator latches; only host clear or reset ends it.
// - Both channels feed data and trigger; external trigger only triggers.
// - Aux connector: trigger out, pacer out, digital out, trigger enable, digital in.
// - Link indicator on once the host link is negotiated.
// - Identification indicator follows a host-writable bit.
// - Fast external clock for 1 to 50 MHz clocks the converter directly.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`include "dcs_regs.vh"
module dcs_sequencer #(
   parameter HB_CYC = `DCS_HB_CYC,
   parameter [31:0] ID_CODE = 32'h00c0ffee
) (
   input wire clk,
   input wire reset,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire sample_valid,
   input wire first_analog_channel_trig,
   input wire second_analog_channel_trig,
   input wire external_trigger_input,
   input wire aux_in,
   input wire base_clock_ok,
   input wire pll_locked,
   input wire link_up,
   input wire power_fault,
   output reg capture_write,
   output reg record_done,
   output reg [1:0] clock_select,
   output reg [7:0] decimation,
   output reg aux_out,
   output reg aux_oe,
   output reg trigger_indicator,
   output reg armed_indicator,
   output reg internal_clock_indicator,
   output reg heartbeat_indicator,
   output reg clock_loss_indicator,
   output reg power_fault_indicator,
   output reg link_indicator,
   output reg id_indicator
);
   localparam ST_IDLE = 2'h0;
   localparam ST_PRE = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam ST_POST = 2'h3;
   reg [31:0] ctrl;
   reg [31:0] reclen;
   reg [31:0] pretrig;
   reg [31:0] reccnt;
   reg [31:0] done_cnt;
   reg [31:0] pre_lat;
   reg [31:0] len_lat;
   reg [31:0] cnt_lat;
   reg [31:0] smp;
   reg [1:0] state;
   reg cfg_err;
   reg ack;
   reg [2:0] s_ta, s_tb, s_te, s_aux, s_bok, s_pll, s_lnk, s_pf;
   reg ta, tb, te, auxv, bok, pll, lnk, pf;
   reg [31:0] hb_cnt;
   reg [15:0] pace_cnt;
   wire acc = (avs_read | avs_write) & ~ack;
   // Write lands at the edge where the master sees waitrequest low
   wire wr = avs_write & ack;
   wire wr_cmd = wr & (avs_address == `DCS_REG_CMD) & avs_byteenable[0];
   wire cmd_arm = wr_cmd & avs_writedata[`DCS_CMD_ARM];
   wire cmd_abort = wr_cmd & avs_writedata[`DCS_CMD_ABORT];
   wire cmd_pfclr = wr_cmd & avs_writedata[`DCS_CMD_PFCLR];
   wire dual = ctrl[`DCS_CTRL_DUAL];
   wire [1:0] tsrc = ctrl[`DCS_CTRL_TSRC_HI:`DCS_CTRL_TSRC_LO];
   wire [2:0] aux_mode = ctrl[`DCS_CTRL_AUX_HI:`DCS_CTRL_AUX_LO];
   wire len_ok = (reclen >= `DCS_RECLEN_MIN) && ((reclen & `DCS_ALIGN_MASK) == 32'h0);
   wire pre_ok = ((pretrig & `DCS_ALIGN_MASK) == 32'h0) &&
      (pretrig <= (dual ? `DCS_PRE_MAX_DUAL : `DCS_PRE_MAX_SINGLE));
   wire cnt_ok = (reccnt != 32'h0);
   wire cfg_ok = len_ok & pre_ok & cnt_ok & (pretrig < reclen);
   reg trig_sel;
   always @* begin
      case (tsrc)
         `DCS_TSRC_A: trig_sel = ta;
         `DCS_TSRC_B: trig_sel = tb;
         `DCS_TSRC_EXT: trig_sel = te;
         default: trig_sel = 1'b0;
      endcase
   end
   wire trig_en = (aux_mode == `DCS_AUX_TRIGEN) ? auxv : 1'b1;
   wire trig_hit = trig_sel & trig_en;
   reg [31:0] rb;
   always @* begin
      case (avs_address)
         `DCS_REG_CTRL: rb = ctrl;
         `DCS_REG_RECLEN: rb = reclen;
         `DCS_REG_PRETRIG: rb = pretrig;
         `DCS_REG_RECCNT: rb = reccnt;
         `DCS_REG_STATUS: rb = {21'h0, auxv, pll, lnk, power_fault_indicator,
            clock_loss_indicator, cfg_err, ~cfg_ok, state, trigger_indicator, armed_indicator};
         `DCS_REG_DONE: rb = done_cnt;
         `DCS_REG_ID: rb = ID_CODE; // Arbitrary identification value
         default: rb = 32'h0;
      endcase
   end
   function [31:0] merge;
      input [31:0] old;
      input [31:0] d;
      input [3:0] be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge[i*8 +: 8] = d[i*8 +: 8];
            end
         end
      end
   endfunction
   // Bus slave: one wait cycle, answer at the second edge
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ack <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         ctrl <= 32'h0;
         reclen <= `DCS_RECLEN_RST;
         pretrig <= 32'h0;
         reccnt <= `DCS_RECCNT_RST;
      end else begin
         ack <= acc;
         avs_waitrequest <= ~acc;
         if (acc & avs_read) begin
            avs_readdata <= rb;
         end
         if (wr) begin
            case (avs_address)
               `DCS_REG_CTRL: ctrl <= merge(ctrl, avs_writedata, avs_byteenable);
               `DCS_REG_RECLEN: reclen <= merge(reclen, avs_writedata, avs_byteenable);
               `DCS_REG_PRETRIG: pretrig <= merge(pretrig, avs_writedata, avs_byteenable);
               `DCS_REG_RECCNT: reccnt <= merge(reccnt, avs_writedata, avs_byteenable);
               default: ;
            endcase
         end
      end
   end
   // Three-stage input synchronisers
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_ta <= 3'h0; s_tb <= 3'h0; s_te <= 3'h0; s_aux <= 3'h0;
         s_bok <= 3'h0; s_pll <= 3'h0; s_lnk <= 3'h0; s_pf <= 3'h0;
         ta <= 1'b0; tb <= 1'b0; te <= 1'b0; auxv <= 1'b0;
         bok <= 1'b0; pll <= 1'b0; lnk <= 1'b0; pf <= 1'b0;
      end else begin
         s_ta <= {s_ta[1:0], first_analog_channel_trig};
         s_tb <= {s_tb[1:0], second_analog_channel_trig};
         s_te <= {s_te[1:0], external_trigger_input};
         s_aux <= {s_aux[1:0], aux_in};
         s_bok <= {s_bok[1:0], base_clock_ok};
         s_pll <= {s_pll[1:0], pll_locked};
         s_lnk <= {s_lnk[1:0], link_up};
         s_pf <= {s_pf[1:0], power_fault};
         if (s_ta[1] == s_ta[2]) ta <= s_ta[2];
         if (s_tb[1] == s_tb[2]) tb <= s_tb[2];
         if (s_te[1] == s_te[2]) te <= s_te[2];
         if (s_aux[1] == s_aux[2]) auxv <= s_aux[2];
         if (s_bok[1] == s_bok[2]) bok <= s_bok[2];
         if (s_pll[1] == s_pll[2]) pll <= s_pll[2];
         if (s_lnk[1] == s_lnk[2]) lnk <= s_lnk[2];
         if (s_pf[1] == s_pf[2]) pf <= s_pf[2];
      end
   end
   // Acquisition state machine
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         cfg_err <= 1'b0;
         pre_lat <= 32'h0;
         len_lat <= 32'h0;
         cnt_lat <= 32'h0;
         smp <= 32'h0;
         done_cnt <= 32'h0;
         capture_write <= 1'b0;
         record_done <= 1'b0;
         trigger_indicator <= 1'b0;
         armed_indicator <= 1'b0;
      end else begin
         record_done <= 1'b0;
         capture_write <= (state != ST_IDLE) & sample_valid & ~cmd_abort;
         if (cmd_abort) begin
            state <= ST_IDLE;
            armed_indicator <= 1'b0;
            trigger_indicator <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (cmd_arm) begin
                     if (cfg_ok) begin
                        cfg_err <= 1'b0;
                        pre_lat <= pretrig;
                        len_lat <= reclen;
                        cnt_lat <= reccnt;
                        done_cnt <= 32'h0;
                        smp <= 32'h0;
                        armed_indicator <= 1'b1;
                        state <= (pretrig == 32'h0) ? ST_WAIT : ST_PRE;
                     end else begin
                        cfg_err <= 1'b1;
                     end
                  end
               end
               ST_PRE: begin
                  if (sample_valid) begin
                     smp <= smp + 32'h1;
                     if (smp + 32'h1 >= pre_lat) begin
                        state <= ST_WAIT;
                     end
                  end
               end
               ST_WAIT: begin
                  if (trig_hit) begin
                     state <= ST_POST;
                     smp <= pre_lat;
                     trigger_indicator <= 1'b1;
                  end
               end
               ST_POST: begin
                  if (sample_valid) begin
                     smp <= smp + 32'h1;
                     if (smp + 32'h1 >= len_lat) begin
                        trigger_indicator <= 1'b0;
                        record_done <= 1'b1;
                        done_cnt <= done_cnt + 32'h1;
                        smp <= 32'h0;
                        if (done_cnt + 32'h1 == cnt_lat) begin
                           state <= ST_IDLE;
                           armed_indicator <= 1'b0;
                        end else begin
                           state <= (pre_lat == 32'h0) ? ST_WAIT : ST_PRE;
                           armed_indicator <= 1'b0;
                        end
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
            if (state == ST_IDLE || state == ST_POST) begin
            end else begin
               armed_indicator <= 1'b1;
            end
         end
      end
   end
   // Clock selection, status indicators and aux connector
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         clock_select <= `DCS_CLK_INT;
         decimation <= 8'h0;
         internal_clock_indicator <= 1'b1;
         heartbeat_indicator <= 1'b0;
         hb_cnt <= 32'h0;
         clock_loss_indicator <= 1'b0;
         power_fault_indicator <= 1'b0;
         link_indicator <= 1'b0;
         id_indicator <= 1'b0;
         aux_out <= 1'b0;
         aux_oe <= 1'b0;
         pace_cnt <= 16'h0;
      end else begin
         clock_select <= ctrl[`DCS_CTRL_CLK_HI:`DCS_CTRL_CLK_LO];
         decimation <= ctrl[`DCS_CTRL_DECIM_HI:`DCS_CTRL_DECIM_LO];
         internal_clock_indicator <= (ctrl[`DCS_CTRL_CLK_HI:`DCS_CTRL_CLK_LO] == `DCS_CLK_INT);
         clock_loss_indicator <= ~bok;
         if (bok) begin
            if (hb_cnt >= HB_CYC - 1) begin
               hb_cnt <= 32'h0;
               heartbeat_indicator <= ~heartbeat_indicator;
            end else begin
               hb_cnt <= hb_cnt + 32'h1;
            end
         end
         if (pf) begin
            power_fault_indicator <= 1'b1;
         end else if (cmd_pfclr) begin
            power_fault_indicator <= 1'b0;
         end
         link_indicator <= lnk;
         id_indicator <= ctrl[`DCS_CTRL_IDLED];
         pace_cnt <= pace_cnt + 16'h1;
         case (aux_mode)
            `DCS_AUX_TRIGOUT: begin
               aux_oe <= 1'b1;
               aux_out <= trigger_indicator;
            end
            `DCS_AUX_PACER: begin
               aux_oe <= 1'b1;
               aux_out <= pace_cnt[decimation[3:0]];
            end
            `DCS_AUX_DIGOUT: begin
               aux_oe <= 1'b1;
               aux_out <= ctrl[`DCS_CTRL_DIGOUT];
            end
            default: begin
               aux_oe <= 1'b0;
               aux_out <= 1'b0;
            end
         endcase
      end
   end
endmodule

// >>> testbench/dcs_host_model.sv
// Host software model: Avalon-MM register transfers
module dcs_host_model (
   input wire clk,
   output logic [3:0] avs_address = 4'h0,
   output logic avs_read = 1'h0,
   output logic avs_write = 1'h0,
   output logic [31:0] avs_writedata = 32'h0,
   output logic [3:0] avs_byteenable = 4'hf,
   input wire avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic xfer(input logic [3:0] a, input logic [31:0] d, input logic rd);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      @(posedge clk);
      while (avs_waitrequest !== 1'h0) @(posedge clk);
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask
endmodule

// >>> testbench/dcs_seq_assertions.sv
// Port checker of the capture sequencer
`include "dcs_regs.vh"
module dcs_seq_chk #(
   parameter HB_CYC = 4
) (
   input wire clk,
   input wire reset,
   input wire [3:0] avs_address,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire avs_waitrequest,
   input wire base_clock_ok,
   input wire link_up,
   input wire power_fault,
   input wire record_done,
   input wire [1:0] clock_select,
   input wire internal_clock_indicator,
   input wire heartbeat_indicator,
   input wire clock_loss_indicator,
   input wire power_fault_indicator,
   input wire link_indicator,
   input wire id_indicator
);
   localparam int HB_LIM = HB_CYC + 4;
   logic [7:0] hb_cnt;
   logic hb_q;
   wire pf_clr = avs_write && avs_address == `DCS_REG_CMD && avs_writedata[`DCS_CMD_PFCLR];
   wire id_wr = avs_write && !avs_waitrequest && avs_address == `DCS_REG_CTRL && avs_byteenable[1];
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles since the heartbeat last changed or clock loss was shown
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         hb_cnt <= 8'h00;
         hb_q <= 1'h0;
      end else begin
         hb_cnt <= (hb_q != heartbeat_indicator || clock_loss_indicator) ? 8'h00 : hb_cnt + 8'h01;
         hb_q <= heartbeat_indicator;
      end
   end
   a_iclk_match: assert property (
      $stable(clock_select) [*2] |-> internal_clock_indicator == (clock_select == `DCS_CLK_INT))
      else $error("internal clock indicator wrong");
   a_hb_running: assert property (hb_cnt <= HB_LIM)
      else $error("heartbeat stalled");
   a_loss_set: assert property (!base_clock_ok [*6] |-> clock_loss_indicator)
      else $error("clock loss not shown");
   a_loss_clear: assert property (base_clock_ok [*6] |-> !clock_loss_indicator)
      else $error("clock loss shown falsely");
   a_pf_hold: assert property (
      power_fault_indicator && !pf_clr |=> power_fault_indicator)
      else $error("power fault indicator dropped");
   a_pf_set: assert property (power_fault [*5] |=> power_fault_indicator)
      else $error("power fault not latched");
   a_link_on: assert property (link_up [*6] |-> link_indicator)
      else $error("link indicator off");
   a_link_off: assert property (!link_up [*6] |-> !link_indicator)
      else $error("link indicator on");
   a_id_follow: assert property (
      id_wr |-> ##2 id_indicator == $past(avs_writedata[`DCS_CTRL_IDLED], 2))
      else $error("id indicator wrong");
   a_done_pulse: assert property (record_done |=> !record_done)
      else $error("record done too long");
endmodule
bind dcs_sequencer dcs_seq_chk #(.HB_CYC(HB_CYC)) dcs_seq_chk_i (.clk, .reset, .avs_address,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .base_clock_ok, .link_up,
   .power_fault, .record_done, .clock_select, .internal_clock_indicator, .heartbeat_indicator,
   .clock_loss_indicator, .power_fault_indicator, .link_indicator, .id_indicator);

// >>> testbench/digitizer_capture_sequencer_tb_top.sv
// Self-checking bench of the capture sequencer
`include "dcs_regs.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module digitizer_capture_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic sample_valid = 1'h0;
   logic sv_en = 1'h0;
   logic [2:0] trg = 3'h0;
   logic aux_in = 1'h0;
   logic base_clock_ok = 1'h1;
   logic pll_locked = 1'h0;
   logic link_up = 1'h0;
   logic power_fault = 1'h0;
   logic [31:0] rs = 32'h00004835;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   wire [3:0] avs_address, avs_byteenable;
   wire avs_read, avs_write, avs_waitrequest, capture_write, record_done, aux_out, aux_oe;
   wire [31:0] avs_writedata, avs_readdata;
   wire [1:0] clock_select;
   wire [7:0] decimation;
   wire trigger_indicator, armed_indicator, internal_clock_indicator, heartbeat_indicator;
   wire clock_loss_indicator, power_fault_indicator, link_indicator, id_indicator;
   always #50 clk = ~clk;
   dcs_host_model dcs_host_model_i (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_waitrequest);
   dcs_sequencer #(.HB_CYC(4)) dcs_sequencer_i (.clk, .reset, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .sample_valid, .first_analog_channel_trig(trg[0]), .second_analog_channel_trig(trg[1]),
      .external_trigger_input(trg[2]), .aux_in, .base_clock_ok, .pll_locked, .link_up,
      .power_fault, .capture_write, .record_done, .clock_select, .decimation, .aux_out, .aux_oe,
      .trigger_indicator, .armed_indicator, .internal_clock_indicator, .heartbeat_indicator,
      .clock_loss_indicator, .power_fault_indicator, .link_indicator, .id_indicator);
   function logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      dcs_host_model_i.xfer(a, d, 1'h0);
   endtask
   task automatic rx(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      dcs_host_model_i.xfer(a, 32'h0, 1'h1);
   endtask
   task automatic pulse(input int s);
      @(posedge clk);
      trg <= 3'h1 << s;
      repeat (4) @(posedge clk);
      trg <= 3'h0;
   endtask
   task automatic wdone();
      for (int i = 0; i < 3000 && record_done !== 1'h1; i++) @(posedge clk);
      `CHK("record_done", 1'h1, record_done)
      `CHK("capture_write", 1'h1, capture_write)
   endtask
   task complete_run();
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Read results, random samples and the run limit
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         complete_run();
      end
      if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
         `CHK("readdata", exp_q[0], avs_readdata & msk_q[0])
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      sample_valid <= sv_en && xs() > 32'h40000000;
      aux_in <= rs[3];
   end
   initial begin
      int s, i;
      logic [31:0] d;
      logic [31:0] rl [7] = '{32'hfa, 32'hf0, 32'h1000, 32'h1000, 32'h1000, 32'h1000, 32'h100};
      logic [31:0] pt [7] = '{32'h0, 32'h0, 32'hff0, 32'h1000, 32'h7f0, 32'h800, 32'h18};
      logic [6:0] good = 7'b0010100;
      logic [6:0] dual = 7'b0110000;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      rx(`DCS_REG_RECLEN, `DCS_RECLEN_RST, 32'hffffffff);
      rx(`DCS_REG_PRETRIG, 32'h0, 32'hffffffff);
      rx(`DCS_REG_RECCNT, `DCS_RECCNT_RST, 32'hffffffff);
      rx(4'h8, 32'h0, 32'hffffffff);
      for (i = 0; i < 7; i++) begin
         wr(`DCS_REG_CTRL, {31'h0, dual[i]});
         wr(`DCS_REG_RECLEN, rl[i]);
         wr(`DCS_REG_PRETRIG, pt[i]);
         wr(`DCS_REG_CMD, 32'h1);
         rx(`DCS_REG_STATUS, good[i] ? 32'h1 : 32'h20, 32'h21);
         wr(`DCS_REG_CMD, 32'h2);
         rx(`DCS_REG_STATUS, 32'h0, 32'h1);
      end
      pll_locked <= 1'h1;
      for (i = 0; i < 5; i++) begin
         d = xs();
         d = (d & 32'h00ff0000) | 32'h200 | (i << 5) | ((i % 3) << 1) | ((i & 1) << 8);
         wr(`DCS_REG_CTRL, d);
         repeat (2) @(posedge clk);
         `CHK("clock_select", 2'(i % 3), clock_select)
         `CHK("internal_clock", i % 3 == 0, internal_clock_indicator)
         `CHK("decimation", d[23:16], decimation)
         `CHK("aux_oe", i < 3, aux_oe)
         `CHK("id", d[8], id_indicator)
         if (i == 2) `CHK("aux_out", 1'h1, aux_out)
      end
      `CHK("link", 1'h0, link_indicator)
      link_up <= 1'h1;
      power_fault <= 1'h1;
      base_clock_ok <= 1'h0;
      repeat (7) @(posedge clk);
      power_fault <= 1'h0;
      `CHK("link", 1'h1, link_indicator)
      `CHK("clock_loss", 1'h1, clock_loss_indicator)
      base_clock_ok <= 1'h1;
      repeat (8) @(posedge clk);
      `CHK("power_fault", 1'h1, power_fault_indicator)
      `CHK("clock_loss", 1'h0, clock_loss_indicator)
      wr(`DCS_REG_CMD, 32'h4);
      repeat (2) @(posedge clk);
      `CHK("power_fault", 1'h0, power_fault_indicator)
      wr(`DCS_REG_RECLEN, 32'h100);
      wr(`DCS_REG_PRETRIG, 32'h20);
      wr(`DCS_REG_RECCNT, 32'h2);
      for (s = 0; s < 3; s++) begin
         wr(`DCS_REG_CTRL, s << 3);
         wr(`DCS_REG_CMD, 32'h1);
         for (i = 0; i < 2; i++) begin
            pulse(s);
            repeat (4) @(posedge clk);
            `CHK("trig_gated", 1'h0, trigger_indicator)
            sv_en <= 1'h1;
            repeat (120) @(posedge clk);
            pulse((s + 1) % 3);
            pulse((s + 2) % 3);
            repeat (4) @(posedge clk);
            rx(`DCS_REG_STATUS, 32'h1, 32'h3);
            pulse(s);
            repeat (4) @(posedge clk);
            `CHK("trig_ind", 1'h1, trigger_indicator)
            wdone();
            sv_en <= 1'h0;
         end
         if (s == 0) rx(`DCS_REG_DONE, 32'h2, 32'hffffffff);
         rx(`DCS_REG_STATUS, 32'h0, 32'h1);
      end
      complete_run();
   end
endmodule
